// ===== src/srw_pkg.sv
package srw_pkg;

  // Time base.
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned RESET_HOLD_MS   = 200;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned RESET_HOLD_CYC  = (CLK_HZ / 1000) * RESET_HOLD_MS;
  localparam int unsigned WDOG_TIMEOUT_CYC = (CLK_HZ / 1000) * WDOG_TIMEOUT_MS;
  localparam int unsigned CNT_W           = 26;

  // Digital results from the analog front end.
  typedef struct packed {
    logic main_low;     // Main supply below reset threshold.
    logic backup_above; // Backup supply exceeds main supply.
    logic pf_below;     // Power fail sense below reference.
    logic backup_mode;  // Battery backup mode active.
  } srw_supply_s;

  // Three-level watch input as two digital samples.
  typedef struct packed {
    logic level; // Driven level of the watch input.
    logic float; // Input floating or at mid-supply.
  } srw_watch_s;

  typedef enum logic [2:0] {
    SRW_HOLD = 3'b001,
    SRW_RUN  = 3'b010,
    SRW_WDRS = 3'b100
  } srw_state_e;

endpackage

// ===== src/srw_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - A below-threshold main supply drives the active-low reset low on the third enabled clock, after two synchroniser stages and the output register.
// - After the supply recovers, reset stays asserted for a further 200 ms.
// - The active-high reset is always the exact complement of the low one.
// - No watch input edge within 1.6 s while enabled gives a reset pulse.
// - Every rising or falling watch input edge restarts the timeout count.
// - A watch input stuck high or low yields a new pulse 1.6 s after each pulse ends.
// - A floating or mid-supply watch input disables the watchdog.
// - In backup mode reset low is held low and reset high is held high.
// - In backup mode the power fail comparison is ignored and its flag is low.
// - In backup mode the watchdog is stopped and issues no pulses.
// - The power fail flag is low when the sense is below 1.25 V or in backup mode, else high.
// - Backup supply is selected only when main is low and backup is higher.
// - Each watchdog reset pulse holds reset asserted for 200 ms.
module srw_supervisor #(
  parameter int unsigned RESET_HOLD_CYC   = srw_pkg::RESET_HOLD_CYC,
  parameter int unsigned WDOG_TIMEOUT_CYC = srw_pkg::WDOG_TIMEOUT_CYC
) (
  input  wire logic                i_sys_clk,          // System clock.
  input  wire logic                i_rst,              // Sync reset, high.
  input  wire logic                i_clk_en,           // Clock enable.
  input  wire srw_pkg::srw_supply_s i_supply,          // Analog results.
  input  wire srw_pkg::srw_watch_s  i_watch_toggle_input, // Watch input.
  output logic                     o_reset_n,          // Processor reset, low.
  output logic                     o_reset,            // Processor reset, high.
  output logic                     o_power_fail_flag_n, // Power fail, low.
  output logic                     o_backup_select     // Backup feeds output.
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [3:0] sup_s1_q;
  logic [3:0] sup_s2_q;
  logic [1:0] wat_s1_q;
  logic [1:0] wat_s2_q;
  logic       wat_prev_q;
  logic [3:0] sup_s1_d;
  logic [3:0] sup_s2_d;
  logic [1:0] wat_s1_d;
  logic [1:0] wat_s2_d;
  logic       wat_prev_d;

  always_comb begin
    sup_s1_d   = i_supply;
    sup_s2_d   = sup_s1_q;
    wat_s1_d   = i_watch_toggle_input;
    wat_s2_d   = wat_s1_q;
    wat_prev_d = wat_s2_q[1];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sup_s1_q   <= 4'h9;
      sup_s2_q   <= 4'h9;
      wat_s1_q   <= 2'h1;
      wat_s2_q   <= 2'h1;
      wat_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      sup_s1_q   <= sup_s1_d;
      sup_s2_q   <= sup_s2_d;
      wat_s1_q   <= wat_s1_d;
      wat_s2_q   <= wat_s2_d;
      wat_prev_q <= wat_prev_d;
    end
  end

  srw_pkg::srw_supply_s sup;
  srw_pkg::srw_watch_s  wat;
  logic                 wd_enable;
  logic                 wd_edge;

  assign sup       = srw_pkg::srw_supply_s'(sup_s2_q);
  assign wat       = srw_pkg::srw_watch_s'(wat_s2_q);
  assign wd_enable = !wat.float && !sup.backup_mode;
  assign wd_edge   = wat.level != wat_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer and watchdog.

  srw_pkg::srw_state_e              state_q;
  srw_pkg::srw_state_e              state_d;
  logic [srw_pkg::CNT_W-1:0]        cnt_q;
  logic [srw_pkg::CNT_W-1:0]        cnt_d;
  logic                             wd_en_q;
  logic                             wd_en_d;

  localparam logic [srw_pkg::CNT_W-1:0] HOLD_LAST =
    srw_pkg::CNT_W'(RESET_HOLD_CYC - 1);
  localparam logic [srw_pkg::CNT_W-1:0] WDOG_LAST =
    srw_pkg::CNT_W'(WDOG_TIMEOUT_CYC - 1);

  function automatic logic [srw_pkg::CNT_W-1:0] inc(
    input logic [srw_pkg::CNT_W-1:0] v
  );
    return v + srw_pkg::CNT_W'(1);
  endfunction

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    wd_en_d = wd_enable;
    if (sup.main_low || sup.backup_mode) begin
      state_d = srw_pkg::SRW_HOLD;
      cnt_d   = '0;
    end else begin
      case (state_q)
        srw_pkg::SRW_HOLD: begin
          if (cnt_q == HOLD_LAST) begin
            state_d = srw_pkg::SRW_RUN;
            cnt_d   = '0;
          end else begin
            cnt_d = inc(cnt_q);
          end
        end
        srw_pkg::SRW_RUN: begin
          if (!wd_enable || wd_edge || !wd_en_q) begin
            cnt_d = '0;
          end else if (cnt_q == WDOG_LAST) begin
            state_d = srw_pkg::SRW_WDRS;
            cnt_d   = '0;
          end else begin
            cnt_d = inc(cnt_q);
          end
        end
        srw_pkg::SRW_WDRS: begin
          if (cnt_q == HOLD_LAST) begin
            state_d = srw_pkg::SRW_RUN;
            cnt_d   = '0;
          end else begin
            cnt_d = inc(cnt_q);
          end
        end
        default: begin
          state_d = srw_pkg::SRW_HOLD;
          cnt_d   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= srw_pkg::SRW_HOLD;
      cnt_q   <= '0;
      wd_en_q <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wd_en_q <= wd_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  logic rst_n_q;
  logic rst_n_d;
  logic pff_n_q;
  logic pff_n_d;
  logic bsel_q;
  logic bsel_d;

  always_comb begin
    rst_n_d = (state_d == srw_pkg::SRW_RUN);
    pff_n_d = !sup.pf_below && !sup.backup_mode;
    bsel_d  = sup.main_low && sup.backup_above;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rst_n_q <= 1'b0;
      pff_n_q <= 1'b1;
      bsel_q  <= 1'b0;
    end else if (i_clk_en) begin
      rst_n_q <= rst_n_d;
      pff_n_q <= pff_n_d;
      bsel_q  <= bsel_d;
    end
  end

  assign o_reset_n           = rst_n_q;
  assign o_reset             = !rst_n_q;
  assign o_power_fail_flag_n = pff_n_q;
  assign o_backup_select     = bsel_q;

endmodule
`default_nettype wire

// ===== tb/srw_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module srw_cpu_model (
  input  wire logic               i_clk,    // Clock.
  input  wire logic               i_drive,  // Buffer on.
  input  wire logic [7:0]         i_period, // Toggle gap, 0 stuck.
  output var srw_pkg::srw_watch_s o_watch   // Watch line.
);
  logic [7:0] cnt = 8'h0;
  logic       lvl = 1'b0;
  initial o_watch = 2'h1;
  always @(negedge i_clk) begin
    cnt <= (cnt >= i_period) ? 8'h0 : cnt + 8'h1;
    if (i_period != 8'h0 && cnt == i_period) lvl <= !lvl;
    // A released line shows no stable level.
    o_watch <= '{level: i_drive ? lvl : !o_watch.level, float: !i_drive};
  end
endmodule
`default_nettype wire

// ===== tb/srw_supervisor_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module srw_supervisor_monitor #(
  parameter int unsigned RESET_HOLD_CYC   = 20,
  parameter int unsigned WDOG_TIMEOUT_CYC = 50
) (
  input wire logic                 i_sys_clk,            // Clock.
  input wire logic                 i_rst,                // Reset.
  input wire logic                 i_clk_en,             // Enable.
  input wire srw_pkg::srw_supply_s i_supply,             // Supply.
  input wire srw_pkg::srw_watch_s  i_watch_toggle_input, // Watch.
  input wire logic                 o_reset_n,            // Reset low.
  input wire logic                 o_reset,              // Reset high.
  input wire logic                 o_power_fail_flag_n,  // Flag.
  input wire logic                 o_backup_select       // Select.
);
  logic [31:0] lo_q;
  logic [31:0] st_q;
  logic        ok;
  logic        sel;
  assign ok = i_clk_en && !i_supply.backup_mode;
  assign sel = i_supply.main_low && i_supply.backup_above;
  // Low time of reset and run time with a stuck watch line.
  always_ff @(posedge i_sys_clk) begin
    lo_q <= (i_rst || o_reset_n) ? 32'h0 : lo_q + 32'h1;
    st_q <= (i_rst || !o_reset_n || i_watch_toggle_input.float || !ok
      || $changed(i_watch_toggle_input.level)) ? 32'h0 : st_q + 32'h1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_comp; o_reset ^ o_reset_n; endproperty
  a_comp: assert property (p_comp) else $error("reset pair");
  property p_low; (i_supply.main_low && i_clk_en)[*4] |-> !o_reset_n;
  endproperty
  a_low: assert property (p_low) else $error("low supply");
  property p_bk; (i_supply.backup_mode && i_clk_en)[*4]
    |-> !o_reset_n && !o_power_fail_flag_n; endproperty
  a_bk: assert property (p_bk) else $error("backup");
  property p_pf; (ok && i_supply.pf_below)[*4] |-> !o_power_fail_flag_n;
  endproperty
  a_pf: assert property (p_pf) else $error("flag low");
  property p_pfh; (ok && !i_supply.pf_below)[*4] |-> o_power_fail_flag_n;
  endproperty
  a_pfh: assert property (p_pfh) else $error("flag high");
  property p_sel; (i_clk_en && sel)[*4] |-> o_backup_select; endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_nsel; (i_clk_en && !sel)[*4] |-> !o_backup_select; endproperty
  a_nsel: assert property (p_nsel) else $error("no select");
  property p_hold; $rose(o_reset_n) |-> lo_q >= RESET_HOLD_CYC; endproperty
  a_hold: assert property (p_hold) else $error("short");
  property p_wd; st_q <= WDOG_TIMEOUT_CYC + 6; endproperty
  a_wd: assert property (p_wd) else $error("no pulse");
  property p_flt; (i_watch_toggle_input.float && ok && !i_supply.main_low)
    [*6] ##0 o_reset_n |=> o_reset_n; endproperty
  a_flt: assert property (p_flt) else $error("disabled");
endmodule
bind srw_supervisor srw_supervisor_monitor #(
  .RESET_HOLD_CYC(RESET_HOLD_CYC), .WDOG_TIMEOUT_CYC(WDOG_TIMEOUT_CYC)
) u_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
  .i_supply(i_supply), .i_watch_toggle_input(i_watch_toggle_input),
  .o_reset_n(o_reset_n), .o_reset(o_reset),
  .o_power_fail_flag_n(o_power_fail_flag_n),
  .o_backup_select(o_backup_select));
`default_nettype wire

// ===== tb/srw_supervisor_test.sv
`timescale 1ns/1ns
`default_nettype none
module srw_supervisor_test;
  logic                 i_sys_clk = 1'b0;
  logic                 i_rst = 1'b1;
  srw_pkg::srw_supply_s i_supply = 4'h8;
  srw_pkg::srw_watch_s  w;
  logic                 drv = 1'b0;
  logic [7:0]           per = 8'h0;
  logic                 o_reset_n, pf_n, bsel, rst_h;
  logic                 en = 1'b1;
  logic [3:0]           r;
  logic [5:0]           q[$];
  int                   failures = 0, cmp_count = 0, seed = 30334;
  event                 ev;
  always #20 i_sys_clk = !i_sys_clk;
  srw_supervisor #(.RESET_HOLD_CYC(20), .WDOG_TIMEOUT_CYC(50)) dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(en),
    .i_supply(i_supply), .i_watch_toggle_input(w), .o_reset_n(o_reset_n),
    .o_reset(rst_h), .o_power_fail_flag_n(pf_n), .o_backup_select(bsel));
  srw_cpu_model cpu (.i_clk(i_sys_clk), .i_drive(drv), .i_period(per),
    .o_watch(w));
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Upper bits of a note mask the outputs that are compared.
  task automatic cmp(input logic [2:0] got, input logic [5:0] e);
    cmp_count++;
    if ((got & e[5:3]) !== (e[2:0] & e[5:3])) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e[2:0]);
    end
    // The high reset must always be the complement of the low one.
    if (rst_h !== !got[2]) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, rst_h, !got[2]);
    end
  endtask
  always @(ev) cmp({o_reset_n, pf_n, bsel}, q.pop_front());
  task automatic ex(input int n, input logic [5:0] e);
    repeat (n) @(negedge i_sys_clk);
    q.push_back(e);
    ->ev;
  endtask
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_rst = 1'b0;
    ex(8, 6'h3a);
    i_supply = 4'h0;
    ex(18, 6'h20);
    ex(10, 6'h24);
    ex(50, 6'h24);
    // A frozen block must not react to a low supply.
    en = 1'b0;
    i_supply = 4'h8;
    ex(10, 6'h24);
    i_supply = 4'h0;
    en = 1'b1;
    ex(50, 6'h24);
    $display("power up done");
    drv = 1'b1;
    per = 8'h1e;
    ex(200, 6'h24);
    drv = 1'b0;
    per = 8'h0;
    repeat (5) @(negedge i_sys_clk);
    drv = 1'b1;
    ex(45, 6'h24);
    ex(15, 6'h20);
    ex(30, 6'h24);
    ex(45, 6'h20);
    $display("watchdog done");
    drv = 1'b0;
    repeat (8) begin
      r = 4'($random(seed)) & 4'he;
      i_supply = r;
      ex(5, {3'h3, 1'b0, !r[1], r[3] & r[2]});
    end
    $display("flags done");
    drv = 1'b1;
    i_supply = 4'hd;
    ex(6, 6'h39);
    ex(120, 6'h39);
    $display("backup done");
    wrap_up();
  end
endmodule
`default_nettype wire
